//--- dfr_cmd_src.sv
// Model of the drive command sources that feed the reference block.
`timescale 1ns/100ps
module dfr_cmd_src (
   input wire logic clk_i,
   output logic run_o,
   output logic rev_o,
   output logic [dfr_pkg::FREQ_W-1:0] freq_o,
   output logic inch_o,
   output logic inch_rev_o
);
   // Idle commands at time zero.
   initial begin
      run_o = 1'b0;
      rev_o = 1'b0;
      freq_o = 16'h0000;
      inch_o = 1'b0;
      inch_rev_o = 1'b0;
   end

   // Commands change after a falling edge only, so no sampling edge sees them move.
   task automatic go(input logic [15:0] f, input logic r);
      @(negedge clk_i);
      run_o = 1'b1;
      rev_o = r;
      freq_o = f;
   endtask
   task automatic halt();
      @(negedge clk_i);
      run_o = 1'b0;
   endtask
   task automatic inch(input logic on, input logic r);
      @(negedge clk_i);
      inch_o = on;
      inch_rev_o = r;
   endtask
endmodule

//--- dfr_hour_cnt.sv
// Hour counter: counts enabled cycles into whole hours and flags a threshold.
`timescale 1ns/100ps
module dfr_hour_cnt #(
   parameter longint HOUR_CYC = dfr_pkg::HOUR_CYC_DEF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic [dfr_pkg::HOUR_W-1:0] thr_i,
   output logic [dfr_pkg::HOUR_W-1:0] hours_o,
   output logic reached_o
);
   import dfr_pkg::*;
   logic [CNT_W-1:0] cyc_reg;

   // Sub-hour cycle count; it freezes once hours saturate so nothing wraps.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_reg <= '0;
      end else if (en_i && hours_o != HOUR_MAX) begin
         if (cyc_reg == CNT_W'(HOUR_CYC - 1)) begin
            cyc_reg <= '0;
         end else begin
            cyc_reg <= cyc_reg + 1'b1;
         end
      end
   end

   // Whole-hour count saturates at its top value.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hours_o <= '0;
      end else if (en_i && hours_o != HOUR_MAX && cyc_reg == CNT_W'(HOUR_CYC - 1)) begin
         hours_o <= hours_o + 1'b1;
      end
   end

   // Threshold flag follows the count one cycle later.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reached_o <= 1'b0;
      end else begin
         reached_o <= (hours_o >= thr_i);
      end
   end
endmodule

//--- dfr_pkg.sv
// Package: constants, types and config bundle of the auxiliary frequency-reference block.
package dfr_pkg;
   // Frequencies are in 0.01 Hz, times in 0.1 s, hours in 1 h.
   localparam int FREQ_W = 16;
   localparam int TIME_W = 16;
   localparam int HOUR_W = 16;
   localparam int CNT_W = 48;
   localparam int CLOCK_MHZ = 100;
   localparam int TIME_UNIT_MS = 100;
   localparam longint TIME_UNIT_CYC_DEF = longint'(TIME_UNIT_MS) * 1000 * CLOCK_MHZ;
   localparam longint HOUR_S = 3600;
   localparam longint HOUR_CYC_DEF = HOUR_S * 1000000 * CLOCK_MHZ;
   localparam logic [FREQ_W-1:0] INCH_FREQ_DEF = 16'h0258;
   localparam logic [FREQ_W-1:0] DROOP_MAX = 16'h03e8;
   localparam logic [HOUR_W-1:0] HOUR_MAX = 16'hffff;
   localparam logic [6:0] LOAD_FULL = 7'h64;
   localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;

   // Below-lower-limit behaviour.
   typedef enum logic [1:0] {
      LOW_RUN_LIMIT = 2'b00,
      LOW_STOP = 2'b01,
      LOW_RUN_ZERO = 2'b10
   } dfr_low_mode_t;

   // Start modes; only direct start is acted on here.
   typedef enum logic [1:0] {
      START_DIRECT = 2'b00,
      START_TRACK = 2'b01,
      START_PREEXC = 2'b10
   } dfr_start_mode_t;

   typedef enum logic {
      STOP_RAMP = 1'b0,
      STOP_FREE = 1'b1
   } dfr_stop_mode_t;

   // Main sequencing states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DEAD = 2'b10
   } dfr_state_t;

   // Configuration bundle held by the drive parameter store.
   typedef struct packed {
      logic [FREQ_W-1:0] max_freq;
      logic [FREQ_W-1:0] inch_freq;
      logic [TIME_W-1:0] inch_acc;
      logic [TIME_W-1:0] inch_dec;
      logic [3:0][TIME_W-1:0] acc;
      logic [3:0][TIME_W-1:0] dec;
      logic [FREQ_W-1:0] skip1;
      logic [FREQ_W-1:0] skip2;
      logic [FREQ_W-1:0] skip_amp;
      logic skip_ramp_en;
      logic [FREQ_W-1:0] acc_sw_freq;
      logic [FREQ_W-1:0] dec_sw_freq;
      logic rev_inhibit;
      logic [TIME_W-1:0] dead_time;
      logic [FREQ_W-1:0] low_limit;
      dfr_low_mode_t low_mode;
      logic [FREQ_W-1:0] droop;
      logic inch_prio;
      logic [HOUR_W-1:0] pon_thr;
      logic [HOUR_W-1:0] run_thr;
      logic run_thr_stop;
      dfr_start_mode_t start_mode;
      logic [TIME_W-1:0] start_brake;
      logic [FREQ_W-1:0] start_freq;
      dfr_stop_mode_t stop_mode;
   } dfr_cfg_t;
endpackage

//--- dfr_ref_aux.sv
// Top: auxiliary frequency-reference processing ahead of the output ramp.
`timescale 1ns/100ps
module dfr_ref_aux #(
   parameter longint TIME_UNIT_CYC = dfr_pkg::TIME_UNIT_CYC_DEF,
   parameter longint HOUR_CYC = dfr_pkg::HOUR_CYC_DEF
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire dfr_pkg::dfr_cfg_t CFG_I,
   input wire logic RUN_CMD_I,
   input wire logic DIR_REV_I,
   input wire logic [dfr_pkg::FREQ_W-1:0] FREQ_SET_I,
   input wire logic INCH_RUN_I,
   input wire logic INCH_REV_I,
   input wire logic [1:0] RAMP_SEL_TERM_I,
   input wire logic RAMP_SEL_ASSIGNED_I,
   input wire logic MOTOR1_SEL_I,
   input wire logic [6:0] LOAD_PCT_I,
   output logic [dfr_pkg::FREQ_W-1:0] FREQ_O,
   output logic REV_O,
   output logic RUNNING_O,
   output logic INCH_ACTIVE_O,
   output dfr_pkg::dfr_start_mode_t START_MODE_O,
   output dfr_pkg::dfr_stop_mode_t STOP_MODE_O,
   output logic [1:0] RAMP_SET_O,
   output logic PON_REACHED_O,
   output logic RUN_REACHED_O
);
   import dfr_pkg::*;

   logic inch_meta_reg, inch_sync_reg, inch_rev_meta_reg, inch_rev_sync_reg;
   logic [1:0] sel_meta_reg, sel_sync_reg;
   dfr_state_t state_reg, state_next;
   logic [FREQ_W-1:0] freq_reg, freq_next;
   logic rev_reg, rev_next;
   logic inch_reg, inch_next;
   logic [CNT_W-1:0] acc_reg, acc_next;
   logic [CNT_W-1:0] dead_reg;
   logic pon_hit, run_hit;
   logic [HOUR_W-1:0] pon_hours, run_hours;

   logic inch_take, want_rev, run_go, low_stop, dir_change, sw_ok, up, down;
   logic [FREQ_W-1:0] base, limited, skipped, drooped, tgt, stepped, droop_amt;
   logic [1:0] set_sel;
   logic [TIME_W-1:0] ramp_time;
   logic [CNT_W-1:0] ramp_thr, dead_thr, acc_sum;

   // Band edges: centred on the skip point, total width equal to amplitude.
   function automatic logic [FREQ_W-1:0] band_lo(input logic [FREQ_W-1:0] c,
                                                  input logic [FREQ_W-1:0] amp);
      band_lo = (c > {1'b0, amp[FREQ_W-1:1]}) ? c - {1'b0, amp[FREQ_W-1:1]} : FREQ_ZERO;
   endfunction

   function automatic logic [FREQ_W-1:0] band_hi(input logic [FREQ_W-1:0] c,
                                                  input logic [FREQ_W-1:0] amp);
      logic [FREQ_W:0] s;
      s = {1'b0, c} + {2'b00, amp[FREQ_W-1:1]};
      band_hi = s[FREQ_W] ? {FREQ_W{1'b1}} : s[FREQ_W-1:0];
   endfunction

   // Move a value inside a band to an edge: nearest edge, or by ramp direction.
   function automatic logic [FREQ_W-1:0] skip_fix(input logic [FREQ_W-1:0] x,
                                                   input logic [FREQ_W-1:0] c,
                                                   input logic [FREQ_W-1:0] amp,
                                                   input logic by_dir,
                                                   input logic dir_up);
      logic [FREQ_W-1:0] lo, hi;
      lo = band_lo(c, amp);
      hi = band_hi(c, amp);
      skip_fix = x;
      if (x > lo && x < hi) begin
         if (by_dir) begin
            skip_fix = dir_up ? hi : lo;
         end else begin
            skip_fix = ((x - lo) <= (hi - x)) ? lo : hi;
         end
      end
   endfunction

   // Two-flop synchronisers for the terminal inputs.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         inch_meta_reg <= 1'b0;
         inch_sync_reg <= 1'b0;
         inch_rev_meta_reg <= 1'b0;
         inch_rev_sync_reg <= 1'b0;
         sel_meta_reg <= 2'h0;
         sel_sync_reg <= 2'h0;
      end else begin
         inch_meta_reg <= INCH_RUN_I;
         inch_sync_reg <= inch_meta_reg;
         inch_rev_meta_reg <= INCH_REV_I;
         inch_rev_sync_reg <= inch_rev_meta_reg;
         sel_meta_reg <= RAMP_SEL_TERM_I;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // Reference shaping: source, lower limit, skip bands, droop, direction.
   always_comb begin
      // Without priority a running drive ignores a new terminal inching request.
      inch_take = inch_sync_reg && (state_reg == ST_IDLE || CFG_I.inch_prio || inch_reg);
      base = inch_take ? CFG_I.inch_freq : FREQ_SET_I;
      limited = base;
      low_stop = 1'b0;
      if (!inch_take && base < CFG_I.low_limit) begin
         unique case (CFG_I.low_mode)
            LOW_RUN_LIMIT: limited = CFG_I.low_limit;
            LOW_STOP: low_stop = 1'b1;
            LOW_RUN_ZERO: limited = FREQ_ZERO;
            default: limited = CFG_I.low_limit;
         endcase
      end
      skipped = limited;
      if (CFG_I.skip1 != FREQ_ZERO || CFG_I.skip2 != FREQ_ZERO) begin
         skipped = skip_fix(limited, CFG_I.skip1, CFG_I.skip_amp, 1'b0, 1'b0);
         skipped = skip_fix(skipped, CFG_I.skip2, CFG_I.skip_amp, 1'b0, 1'b0);
      end
      // Droop scales linearly with load percent, capped at its full amount.
      droop_amt = FREQ_W'(({1'b0, (CFG_I.droop > DROOP_MAX) ? DROOP_MAX : CFG_I.droop}
                  * (LOAD_PCT_I > LOAD_FULL ? LOAD_FULL : LOAD_PCT_I)) / LOAD_FULL);
      drooped = (skipped > droop_amt) ? skipped - droop_amt : FREQ_ZERO;
      want_rev = inch_take ? inch_rev_sync_reg : DIR_REV_I;
      // The runtime stop holds for as long as the running hours stay reached.
      run_go = (RUN_CMD_I || inch_take) && !low_stop
               && !(run_hit && CFG_I.run_thr_stop)
               && !(want_rev && CFG_I.rev_inhibit);
      dir_change = run_go && (want_rev != rev_reg);
      tgt = (run_go && !dir_change) ? drooped : FREQ_ZERO;
   end

   // Ramp set choice: terminals, frequency switchover, or inching set.
   always_comb begin
      sw_ok = MOTOR1_SEL_I && !RAMP_SEL_ASSIGNED_I;
      set_sel = RAMP_SEL_ASSIGNED_I ? sel_sync_reg : 2'h0;
      up = freq_reg < tgt;
      down = freq_reg > tgt;
      if (inch_reg) begin
         ramp_time = up ? CFG_I.inch_acc : CFG_I.inch_dec;
      end else if (sw_ok && up) begin
         ramp_time = (freq_reg < CFG_I.acc_sw_freq) ? CFG_I.acc[0] : CFG_I.acc[1];
         set_sel = (freq_reg < CFG_I.acc_sw_freq) ? 2'h0 : 2'h1;
      end else if (sw_ok) begin
         ramp_time = (freq_reg > CFG_I.dec_sw_freq) ? CFG_I.dec[0] : CFG_I.dec[1];
         set_sel = (freq_reg > CFG_I.dec_sw_freq) ? 2'h0 : 2'h1;
      end else begin
         ramp_time = up ? CFG_I.acc[set_sel] : CFG_I.dec[set_sel];
      end
      ramp_thr = CNT_W'(ramp_time) * CNT_W'(TIME_UNIT_CYC);
      dead_thr = CNT_W'(CFG_I.dead_time) * CNT_W'(TIME_UNIT_CYC);
      acc_sum = acc_reg + CNT_W'(CFG_I.max_freq);
      stepped = up ? freq_reg + 1'b1 : freq_reg - 1'b1;
      if (CFG_I.skip_ramp_en && (CFG_I.skip1 != FREQ_ZERO || CFG_I.skip2 != FREQ_ZERO)) begin
         stepped = skip_fix(stepped, CFG_I.skip1, CFG_I.skip_amp, 1'b1, up);
         stepped = skip_fix(stepped, CFG_I.skip2, CFG_I.skip_amp, 1'b1, up);
      end
   end

   // Sequencer and ramp: rate is full scale per ramp time, one step at most per cycle; a zero ramp time jumps straight to the target.
   always_comb begin
      state_next = state_reg;
      freq_next = freq_reg;
      rev_next = rev_reg;
      inch_next = inch_reg;
      acc_next = '0;
      unique case (state_reg)
         ST_IDLE: begin
            inch_next = inch_take;
            if (run_go) begin
               state_next = ST_RUN;
               rev_next = want_rev;
               // Direct start with no braking time launches at the startup frequency, or at the reference if that is lower.
               if ((inch_take || CFG_I.start_mode == START_DIRECT)
                   && CFG_I.start_brake == '0) begin
                  freq_next = (CFG_I.start_freq < drooped) ? CFG_I.start_freq : drooped;
               end
            end
         end
         ST_RUN: begin
            inch_next = inch_take;
            if (!run_go && !inch_reg && CFG_I.stop_mode == STOP_FREE) begin
               freq_next = FREQ_ZERO;
               state_next = ST_IDLE;
            end else if (freq_reg == FREQ_ZERO && dir_change) begin
               state_next = ST_DEAD;
            end else if (freq_reg == FREQ_ZERO && !run_go) begin
               state_next = ST_IDLE;
            end else if (up || down) begin
               if (ramp_time == '0) begin
                  freq_next = tgt;
               end else if (acc_sum >= ramp_thr) begin
                  freq_next = stepped;
                  acc_next = acc_sum - ramp_thr;
               end else begin
                  acc_next = acc_sum;
               end
            end
         end
         ST_DEAD: begin
            freq_next = FREQ_ZERO;
            if (!run_go) begin
               state_next = ST_IDLE;
            end else if (dead_reg >= dead_thr) begin
               rev_next = want_rev;
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // Sequencer state, output frequency, direction and inching flag.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= ST_IDLE;
         freq_reg <= FREQ_ZERO;
         rev_reg <= 1'b0;
         inch_reg <= 1'b0;
         acc_reg <= '0;
      end else begin
         state_reg <= state_next;
         freq_reg <= freq_next;
         rev_reg <= rev_next;
         inch_reg <= inch_next;
         acc_reg <= acc_next;
      end
   end

   // Dead-time counter runs only in the zero-frequency hold.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dead_reg <= '0;
      end else if (state_reg == ST_DEAD) begin
         dead_reg <= dead_reg + 1'b1;
      end else begin
         dead_reg <= '0;
      end
   end

   // Registered outputs; effective modes are forced while inching.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FREQ_O <= FREQ_ZERO;
         REV_O <= 1'b0;
         RUNNING_O <= 1'b0;
         INCH_ACTIVE_O <= 1'b0;
         START_MODE_O <= START_DIRECT;
         STOP_MODE_O <= STOP_RAMP;
         RAMP_SET_O <= 2'h0;
         PON_REACHED_O <= 1'b0;
         RUN_REACHED_O <= 1'b0;
      end else begin
         FREQ_O <= freq_next;
         REV_O <= rev_next;
         RUNNING_O <= (state_next != ST_IDLE);
         INCH_ACTIVE_O <= inch_next;
         START_MODE_O <= inch_next ? START_DIRECT : CFG_I.start_mode;
         STOP_MODE_O <= inch_next ? STOP_RAMP : CFG_I.stop_mode;
         RAMP_SET_O <= set_sel;
         PON_REACHED_O <= pon_hit;
         RUN_REACHED_O <= run_hit;
      end
   end

   // Power-on hours count whenever the block is out of reset.
   dfr_hour_cnt #(.HOUR_CYC(HOUR_CYC)) u_pon_hours (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .en_i(1'b1),
      .thr_i(CFG_I.pon_thr),
      .hours_o(pon_hours),
      .reached_o(pon_hit)
   );

   // Running hours count only while the output is live.
   dfr_hour_cnt #(.HOUR_CYC(HOUR_CYC)) u_run_hours (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .en_i(state_reg != ST_IDLE),
      .thr_i(CFG_I.run_thr),
      .hours_o(run_hours),
      .reached_o(run_hit)
   );
endmodule

//--- dfr_ref_aux_assertions.sv
// Checker: timing relations between the ports of the reference block.
`timescale 1ns/100ps
module dfr_ref_aux_chk
   import dfr_pkg::*;
#(
   parameter longint TIME_UNIT_CYC = dfr_pkg::TIME_UNIT_CYC_DEF
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire dfr_pkg::dfr_cfg_t CFG_I,
   input wire logic INCH_RUN_I,
   input wire logic [1:0] RAMP_SEL_TERM_I,
   input wire logic RAMP_SEL_ASSIGNED_I,
   input wire logic MOTOR1_SEL_I,
   input wire logic [dfr_pkg::FREQ_W-1:0] FREQ_O,
   input wire logic REV_O,
   input wire logic RUNNING_O,
   input wire logic INCH_ACTIVE_O,
   input wire dfr_pkg::dfr_start_mode_t START_MODE_O,
   input wire dfr_pkg::dfr_stop_mode_t STOP_MODE_O,
   input wire logic [1:0] RAMP_SET_O,
   input wire logic PON_REACHED_O,
   input wire logic RUN_REACHED_O
);
   logic [31:0] zero_cnt_reg;

   // Running cycles spent at zero; a direction flip must follow a long enough run of them.
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         zero_cnt_reg <= 32'h0;
      end else if (RUNNING_O && FREQ_O == FREQ_ZERO) begin
         zero_cnt_reg <= zero_cnt_reg + 32'h1;
      end else begin
         zero_cnt_reg <= 32'h0;
      end
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   // The synchronisers add two edges, so pins must be held for several cycles.
   sequence prio_inch_held;
      (CFG_I.inch_prio && RUNNING_O && INCH_RUN_I)[*4];
   endsequence
   sequence term_steady;
      (RAMP_SEL_ASSIGNED_I && !INCH_ACTIVE_O && $stable(RAMP_SEL_TERM_I))[*5];
   endsequence
   sequence no_switch;
      (!RAMP_SEL_ASSIGNED_I && !MOTOR1_SEL_I && !INCH_ACTIVE_O)[*2];
   endsequence

   AST_INCH_MODES: assert property (INCH_ACTIVE_O |->
      START_MODE_O == START_DIRECT && STOP_MODE_O == STOP_RAMP) else $error("inch modes");
   AST_IDLE_ZERO: assert property (!RUNNING_O |-> FREQ_O == FREQ_ZERO)
      else $error("idle with frequency");
   AST_SKIP_RAMP: assert property (RUNNING_O && !INCH_ACTIVE_O && CFG_I.skip_ramp_en &&
      CFG_I.skip1 != FREQ_ZERO && $stable(CFG_I) |-> !(FREQ_O > CFG_I.skip1 - (CFG_I.skip_amp >> 1)
      && FREQ_O < CFG_I.skip1 + (CFG_I.skip_amp >> 1))) else $error("inside skip band");
   AST_REV_ALLOWED: assert property ($rose(REV_O) |-> !$past(CFG_I.rev_inhibit))
      else $error("reverse while inhibited");
   AST_DEAD_TIME: assert property ($changed(REV_O) && $past(RUNNING_O) |->
      zero_cnt_reg >= CFG_I.dead_time * TIME_UNIT_CYC + 1) else $error("dead time short");
   AST_INCH_PRIO: assert property (prio_inch_held |-> INCH_ACTIVE_O)
      else $error("inching not taken");
   AST_TERM_SET: assert property (term_steady |-> RAMP_SET_O == RAMP_SEL_TERM_I)
      else $error("ramp set differs from terminals");
   AST_SWITCH_UP: assert property (!RAMP_SEL_ASSIGNED_I && MOTOR1_SEL_I && !INCH_ACTIVE_O &&
      FREQ_O == $past(FREQ_O) + 16'h0001 && FREQ_O > CFG_I.acc_sw_freq + 16'h0002
      |-> RAMP_SET_O == 2'h1) else $error("ramp-up set wrong");
   AST_SWITCH_DOWN: assert property (!RAMP_SEL_ASSIGNED_I && MOTOR1_SEL_I && !INCH_ACTIVE_O &&
      FREQ_O + 16'h0001 == $past(FREQ_O) && FREQ_O + 16'h0002 < CFG_I.dec_sw_freq
      |-> RAMP_SET_O == 2'h1) else $error("ramp-down set wrong");
   AST_NO_SWITCH: assert property (no_switch |-> RAMP_SET_O == 2'h0)
      else $error("switchover without motor one");
   // The reached flags lag the threshold by two edges, so the config must be older than that.
   AST_RUN_HOLD: assert property (RUN_REACHED_O && CFG_I.run_thr_stop && !RUNNING_O &&
      $stable(CFG_I) && $past(CFG_I) == $past(CFG_I, 2) |=> !RUNNING_O)
      else $error("restart after running limit");
   AST_PON_HOLD: assert property (PON_REACHED_O &&
      $past(CFG_I.pon_thr) == $past(CFG_I.pon_thr, 2) |=> PON_REACHED_O)
      else $error("power-on flag dropped");
endmodule

bind dfr_ref_aux dfr_ref_aux_chk #(.TIME_UNIT_CYC(TIME_UNIT_CYC)) chk (.*);

//--- test_dfr_ref_aux.sv
// Testbench: self-checking scenarios for the auxiliary frequency-reference block.
`timescale 1ns/100ps
module test_dfr_ref_aux;
   import dfr_pkg::*;
   logic CLOCK_I = 1'b0;
   logic RST_N_I = 1'b0;
   dfr_cfg_t CFG_I;
   logic RUN_CMD_I, DIR_REV_I, INCH_RUN_I, INCH_REV_I;
   logic [15:0] FREQ_SET_I, FREQ_O;
   logic [1:0] RAMP_SEL_TERM_I = 2'h0;
   logic RAMP_SEL_ASSIGNED_I = 1'b0;
   logic MOTOR1_SEL_I = 1'b0;
   logic [6:0] LOAD_PCT_I = 7'h00;
   logic REV_O, RUNNING_O, INCH_ACTIVE_O, PON_REACHED_O, RUN_REACHED_O;
   dfr_start_mode_t START_MODE_O;
   dfr_stop_mode_t STOP_MODE_O;
   logic [1:0] RAMP_SET_O;
   int bad_count = 0;
   int total_checks = 0;

   // Small time bases keep ramps, dead time and hour counts short.
   dfr_ref_aux #(.TIME_UNIT_CYC(4), .HOUR_CYC(20)) dut (.*);
   dfr_cmd_src src (.clk_i(CLOCK_I), .run_o(RUN_CMD_I), .rev_o(DIR_REV_I),
      .freq_o(FREQ_SET_I), .inch_o(INCH_RUN_I), .inch_rev_o(INCH_REV_I));

   always #5 CLOCK_I = ~CLOCK_I;

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] probe(input int s);
      case (s)
         0: probe = FREQ_O;
         1: probe = 16'(RUNNING_O);
         2: probe = 16'(INCH_ACTIVE_O);
         4: probe = 16'(RUN_REACHED_O);
         default: probe = 16'(PON_REACHED_O);
      endcase
   endfunction
   // Bounded wait; a spent bound is a mismatch and ends the run.
   task automatic wt(input int s, input logic [15:0] e, input int lim);
      for (int n = 0; n < lim && probe(s) !== e; n++) @(negedge CLOCK_I);
      chk(probe(s), e);
      if (probe(s) !== e) conclude();
   endtask
   task automatic setf(input logic [15:0] f, input logic [15:0] e);
      src.go(f, 1'b0);
      repeat (3) @(negedge CLOCK_I);
      chk(FREQ_O, e);
   endtask
   task automatic stop_idle();
      src.halt();
      wt(1, 16'h0000, 12);
   endtask

   task automatic sc_skip();
      @(negedge CLOCK_I);
      CFG_I.skip1 = 16'h03e8;
      CFG_I.skip_amp = 16'h00c8;
      setf(16'h03e8, 16'h0384);
      setf(16'h041a, 16'h044c);
      setf(16'h03b6, 16'h0384);
      setf(16'h0352, 16'h0352);
      setf(16'h044c, 16'h044c);
      CFG_I.skip1 = 16'h0000;
      CFG_I.skip2 = 16'h07d0;
      setf(16'h079e, 16'h076c);
      CFG_I.skip2 = 16'h0000;
      setf(16'h03e8, 16'h03e8);
      stop_idle();
   endtask
   task automatic sc_low();
      logic [15:0] fx[3] = '{16'h01f4, 16'h0000, 16'h0000};
      logic [15:0] rx[3] = '{16'h0001, 16'h0000, 16'h0001};
      CFG_I.low_limit = 16'h01f4;
      for (int m = 0; m < 3; m++) begin
         @(negedge CLOCK_I);
         CFG_I.low_mode = dfr_low_mode_t'(2'(m));
         src.go(16'h012c, 1'b0);
         repeat (3) @(negedge CLOCK_I);
         chk(FREQ_O, fx[m]);
         chk(16'(RUNNING_O), rx[m]);
         stop_idle();
      end
      CFG_I.low_limit = 16'h0000;
   endtask
   task automatic sc_droop();
      logic [6:0] ld[3] = '{7'h32, 7'h64, 7'h64};
      logic [15:0] dr[3] = '{16'h00c8, 16'h00c8, 16'h07d0};
      logic [15:0] ex[3] = '{16'h076c, 16'h0708, 16'h03e8};
      src.go(16'h07d0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         @(negedge CLOCK_I);
         CFG_I.droop = dr[i];
         LOAD_PCT_I = ld[i];
         repeat (3) @(negedge CLOCK_I);
         chk(FREQ_O, ex[i]);
      end
      CFG_I.droop = 16'h0000;
      LOAD_PCT_I = 7'h00;
      stop_idle();
   endtask
   task automatic sc_reverse();
      int n = 0;
      CFG_I.dead_time = 16'h0002;
      setf(16'h03e8, 16'h03e8);
      src.go(16'h03e8, 1'b1);
      for (int i = 0; i < 40 && REV_O !== 1'b1; i++) begin
         @(negedge CLOCK_I);
         if (FREQ_O === 16'h0000) n++;
      end
      chk(16'(n > 8 && n < 12), 16'h0001);
      wt(0, 16'h03e8, 8);
      chk(16'(REV_O), 16'h0001);
      CFG_I.rev_inhibit = 1'b1;
      wt(1, 16'h0000, 8);
      repeat (4) @(negedge CLOCK_I);
      chk(16'(RUNNING_O), 16'h0000);
      CFG_I.rev_inhibit = 1'b0;
      CFG_I.dead_time = 16'h0000;
      stop_idle();
   endtask
   task automatic sc_inch();
      CFG_I.start_mode = START_TRACK;
      CFG_I.stop_mode = STOP_FREE;
      CFG_I.inch_prio = 1'b1;
      setf(16'h05dc, 16'h05dc);
      src.inch(1'b1, 1'b0);
      wt(2, 16'h0001, 8);
      wt(0, INCH_FREQ_DEF, 4);
      chk(16'({START_MODE_O, STOP_MODE_O}), 16'({START_DIRECT, STOP_RAMP}));
      src.inch(1'b0, 1'b0);
      stop_idle();
      CFG_I.inch_prio = 1'b0;
      setf(16'h05dc, 16'h05dc);
      src.inch(1'b1, 1'b0);
      repeat (6) @(negedge CLOCK_I);
      chk(16'(INCH_ACTIVE_O), 16'h0000);
      src.inch(1'b0, 1'b0);
      stop_idle();
      CFG_I.start_mode = START_DIRECT;
      CFG_I.stop_mode = STOP_RAMP;
   endtask
   // One step a cycle: max_freq covers the count of a 1 s ramp at once.
   task automatic sc_ramp();
      CFG_I.acc[1:0] = {16'h000a, 16'h000a};
      CFG_I.dec[1:0] = {16'h000a, 16'h000a};
      CFG_I.start_freq = 16'h012c;
      CFG_I.acc_sw_freq = 16'h01f4;
      CFG_I.dec_sw_freq = 16'h01f4;
      CFG_I.skip_ramp_en = 1'b1;
      CFG_I.skip1 = 16'h03e8;
      MOTOR1_SEL_I = 1'b1;
      src.go(16'h05dc, 1'b0);
      @(negedge CLOCK_I);
      chk(FREQ_O, 16'h012c);
      wt(0, 16'h05dc, 1500);
      src.halt();
      wt(1, 16'h0000, 1700);
      CFG_I.acc = '0;
      CFG_I.dec = '0;
      CFG_I.skip1 = 16'h0000;
      CFG_I.skip_ramp_en = 1'b0;
      CFG_I.start_freq = 16'h0000;
   endtask
   task automatic sc_terms();
      setf(16'h03e8, 16'h03e8);
      RAMP_SEL_ASSIGNED_I = 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(negedge CLOCK_I);
         RAMP_SEL_TERM_I = 2'(k);
         repeat (6) @(negedge CLOCK_I);
         chk(16'(RAMP_SET_O), 16'(k));
      end
      RAMP_SEL_ASSIGNED_I = 1'b0;
      stop_idle();
   endtask
   task automatic sc_hours();
      setf(16'h03e8, 16'h03e8);
      CFG_I.run_thr = 16'h0001;
      wt(4, 16'h0001, 6);
      chk(16'(RUNNING_O), 16'h0001);
      CFG_I.run_thr_stop = 1'b1;
      wt(1, 16'h0000, 8);
      repeat (4) @(negedge CLOCK_I);
      chk(16'(RUNNING_O), 16'h0000);
      CFG_I.pon_thr = 16'h0001;
      wt(5, 16'h0001, 6);
      CFG_I.pon_thr = 16'hffff;
      repeat (4) @(negedge CLOCK_I);
      chk(16'(PON_REACHED_O), 16'h0000);
   endtask

   // Main sequence: reset, then each scenario in turn.
   initial begin
      CFG_I = '0;
      CFG_I.max_freq = 16'h1388;
      CFG_I.inch_freq = INCH_FREQ_DEF;
      CFG_I.pon_thr = 16'hffff;
      CFG_I.run_thr = 16'hffff;
      repeat (20) @(posedge CLOCK_I);
      @(negedge CLOCK_I);
      RST_N_I = 1'b1;
      @(negedge CLOCK_I);
      chk(16'({REV_O, RUNNING_O, INCH_ACTIVE_O, START_MODE_O, STOP_MODE_O}), 16'h0000);
      sc_skip();
      sc_low();
      sc_droop();
      sc_reverse();
      sc_inch();
      sc_ramp();
      sc_terms();
      sc_hours();
      conclude();
   end
endmodule
